// ==== omsc_pkg.sv ====
package omsc_pkg;

    // register addresses, low 16 bits
    localparam logic [15:0] MODE_READBACK_ADDR = 16'hfff1;
    localparam logic [15:0] SYS_CTRL_ADDR      = 16'hfff2;
    localparam logic [15:0] AREA_WIDTH_ADDR    = 16'hffe0;
    localparam logic [15:0] AREA_WAIT_ADDR     = 16'hffe1;

    // system control fields and reset value
    localparam logic [7:0] SYS_CTRL_RESET = 8'h0b;
    localparam logic [7:0] SYS_CTRL_WMASK = 8'hfd;
    localparam logic [7:0] SYS_CTRL_ONES  = 8'h02;
    localparam int         SC_STBY_BIT    = 7;
    localparam int         SC_WAIT_LSB    = 4;
    localparam int         SC_UFE_BIT     = 3;
    localparam int         SC_NMI_BIT     = 2;
    localparam int         SC_RAM_BIT     = 0;

    // mode readback fixed bits
    localparam logic [7:0] MODE_RB_FIXED  = 8'hc0;

    // area control reset values
    localparam logic [7:0] AREA_ALL_WIDE  = 8'hff;
    localparam logic [7:0] AREA_ALL_NARROW = 8'h00;
    localparam logic [7:0] AREA_WAIT_RESET = 8'hff;

    // access lengths in states
    localparam logic [1:0] MEM_STATES     = 2'h2;
    localparam logic [1:0] PERIPH_STATES  = 2'h3;
    localparam logic [1:0] EXT_FAST_STATES = 2'h2;
    localparam logic [1:0] EXT_SLOW_STATES = 2'h3;

    // timing: one state is one clock period
    localparam int         CLK_PERIOD_NS  = 50;
    localparam int         WAIT_BASE_STATES = 8192;
    localparam logic [2:0] WAIT_CODE_MAX  = 3'h4;
    localparam int         SETTLE_MIN_MS  = 8;
    localparam int         SETTLE_MIN_CYC = (SETTLE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // power states, gray along standby-settle-run-sleep
    typedef enum logic [1:0] {
        PWR_RUN     = 2'h0,
        PWR_SLEEP   = 2'h1,
        PWR_STANDBY = 2'h3,
        PWR_SETTLE  = 2'h2
    } omsc_pwr_e;

    // access target
    typedef enum logic [1:0] {
        SP_MEM    = 2'h0,
        SP_PERIPH = 2'h1,
        SP_EXT    = 2'h2
    } omsc_space_e;

    // address space size
    typedef enum logic [1:0] {
        AS_NONE = 2'h0,
        AS_64K  = 2'h1,
        AS_1M   = 2'h2,
        AS_16M  = 2'h3
    } omsc_asz_e;

    // access request carrier
    typedef struct packed {
        logic        req;
        omsc_space_e space;
        logic [2:0]  area;
        logic        reg16;
    } omsc_acc_s;

    // decoded mode carrier
    typedef struct packed {
        logic      valid;
        logic      expanded;
        logic      rom_en;
        logic      init16;
        omsc_asz_e asz;
    } omsc_mode_s;

    // strap decode
    function automatic omsc_mode_s omsc_decode_mode(input logic [2:0] pins);
        omsc_mode_s m;
        m = '{valid: 1'b1, expanded: 1'b1, rom_en: 1'b0, init16: 1'b0, asz: AS_1M};
        case (pins)
            3'h1: m.init16 = 1'b0;
            3'h2: m.init16 = 1'b1;
            3'h3: m.asz = AS_16M;
            3'h4: begin
                m.asz    = AS_16M;
                m.init16 = 1'b1;
            end
            3'h5: m.rom_en = 1'b1;
            3'h6: begin
                m.expanded = 1'b0;
                m.rom_en   = 1'b1;
                m.asz      = AS_64K;
            end
            3'h7: begin
                m.expanded = 1'b0;
                m.rom_en   = 1'b1;
            end
            default: m = '{valid: 1'b0, expanded: 1'b0, rom_en: 1'b0, init16: 1'b0, asz: AS_NONE};
        endcase
        return m;
    endfunction

endpackage

// ==== omsc_state_ctr.sv ====
`timescale 1ns/1ns
module omsc_state_ctr
    import omsc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // access start and length
    input  wire logic       start_in,
    input  wire logic [1:0] len_in,
    // progress
    output logic            busy_out,
    output logic            last_out
);

    // counter state
    typedef struct packed {
        logic       active;
        logic [1:0] cnt;
        logic [1:0] len;
    } omsc_ctr_s;

    omsc_ctr_s q_reg;     // registered state
    omsc_ctr_s q_next;    // next state

    // one count per state of the cycle
    always_comb begin
        q_next = q_reg;
        if (start_in) begin
            q_next.active = 1'b1;
            q_next.cnt    = 2'h1;
            q_next.len    = len_in;
        end else if (q_reg.active) begin
            if (q_reg.cnt == q_reg.len) begin
                q_next.active = 1'b0;
            end else begin
                q_next.cnt = q_reg.cnt + 2'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign busy_out = q_reg.active;
    assign last_out = q_reg.active && (q_reg.cnt == q_reg.len);

    // a cycle never runs past its length
    cnt_bound_a: assert property (@(posedge clk_in) disable iff (srst_in)
        q_reg.active |-> (q_reg.cnt >= 2'h1 && q_reg.cnt <= q_reg.len && q_reg.len >= 2'h2))
        else $error("state count out of range");

endmodule

// ==== omsc_ctrl.sv ====
// Contract
// - a state is one clock; cycles 2-3
// - on-chip memory: two states, 16-bit path
// - peripheral registers: three states, 8/16-bit path
// - eight areas, each width and states
// - strap pattern picks mode; zero unused
// - initial bus width set by mode
// - address space size set by mode
// - ROM and external access set by mode
// - RAM disabled routes to external space
// - external bus wide if any area wide
// - readback: 11, 000, then strap levels
// - straps latched when readback is read
// - standby bit picks sleep or standby
// - standby bit survives wake; software clears
// - wait code picks settle length
// - wait selected states after standby exit
// - bit 3 steers the user flag
// - control register resets to 0x0b
// - user flag mask when 0, flag when 1
// - bit 2 picks NMI edge
// - bit 0 enables RAM, reset sets it
// - bit 1 reads as one
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module omsc_ctrl
    import omsc_pkg::*;
#(
    parameter int WAIT_BASE = WAIT_BASE_STATES    // shortest settle, in states
)
(
    // clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        SRST_IN,
    // register port
    input  wire logic [15:0] REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    // mode straps
    input  wire logic [2:0]  MODE_STRAP_PINS_IN,
    // power control
    input  wire logic        SLEEP_REQ_IN,
    input  wire logic        WAKE_IRQ_IN,
    input  wire logic        EXT_IRQ_IN,
    output omsc_pwr_e        PWR_STATE_OUT,
    output logic             WAIT_SHORT_OUT,
    // access timing
    input  wire omsc_acc_s   ACC_IN,
    output logic             ACC_BUSY_OUT,
    output logic             ACC_DONE_OUT,
    output logic             ACC_WIDE_OUT,
    // mode and control outputs
    output omsc_mode_s       MODE_CFG_OUT,
    output logic             EXT_BUS16_OUT,
    output logic             RAM_EN_OUT,
    output logic             RAM_TO_EXT_OUT,
    output logic             USER_FLAG_MASK_OUT,
    output logic             NMI_RISING_OUT
);

    // whole block state
    typedef struct packed {
        omsc_pwr_e   pwr;
        logic [7:0]  sysctl;
        logic [7:0]  area_w;
        logic [7:0]  area_t;
        logic [7:0]  rdata;
        logic [17:0] settle_cnt;
        omsc_mode_s  cfg;
        logic        ext16;
        logic        ram_ext;
        logic        wait_short;
        logic        acc_wide;
        logic        acc_done;
        logic        ufmask;
    } omsc_state_s;

    omsc_state_s q_reg;     // registered state
    omsc_state_s q_next;    // next state
    omsc_state_s q_rst;     // value loaded under reset

    omsc_mode_s  strap_cfg;     // live strap decode
    logic [2:0]  wait_code;     // saturated wait code
    logic [17:0] wait_cycles;   // selected settle length
    logic        acc_start;     // access taken this cycle
    logic [1:0]  acc_len;       // states of the taken access
    logic        ctr_busy;      // access cycle running
    logic        ctr_last;      // last state of the cycle

    // strap decode, straps assumed steady
    assign strap_cfg = omsc_decode_mode(MODE_STRAP_PINS_IN);

    // settle length: codes above 100 saturate
    always_comb begin
        wait_code = q_reg.sysctl[SC_WAIT_LSB +: 3];
        if (wait_code > WAIT_CODE_MAX) begin
            wait_code = WAIT_CODE_MAX;
        end
        wait_cycles = 18'(WAIT_BASE) << wait_code;
    end

    // reset image; area widths follow the mode
    always_comb begin
        q_rst        = '0;
        q_rst.pwr    = PWR_RUN;
        q_rst.sysctl = SYS_CTRL_RESET;
        q_rst.cfg    = strap_cfg;
        q_rst.area_t = AREA_WAIT_RESET;
        // wide areas from reset already make a wide bus
        q_rst.ext16  = strap_cfg.expanded && strap_cfg.init16;
        q_rst.ufmask = !SYS_CTRL_RESET[SC_UFE_BIT];
        if (strap_cfg.init16) begin
            q_rst.area_w = AREA_ALL_WIDE;
        end else begin
            q_rst.area_w = AREA_ALL_NARROW;
        end
    end

    // access start and length
    always_comb begin
        acc_start = ACC_IN.req && !ctr_busy;
        case (ACC_IN.space)
            SP_MEM:    acc_len = MEM_STATES;
            SP_PERIPH: acc_len = PERIPH_STATES;
            SP_EXT: begin
                if (q_reg.area_t[ACC_IN.area]) begin
                    acc_len = EXT_SLOW_STATES;
                end else begin
                    acc_len = EXT_FAST_STATES;
                end
            end
            default:   acc_len = PERIPH_STATES;
        endcase
    end

    // next state
    always_comb begin
        q_next          = q_reg;
        q_next.rdata    = 8'h00;
        q_next.acc_done = ctr_last;
        q_next.cfg      = strap_cfg;
        // data bus width across areas
        q_next.ext16    = q_reg.cfg.expanded && (|q_reg.area_w);
        // disabled RAM hands its range to the external bus
        q_next.ram_ext  = q_reg.cfg.expanded && !q_reg.sysctl[SC_RAM_BIT];
        q_next.wait_short = 32'(wait_cycles) < SETTLE_MIN_CYC;

        // register reads
        if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                MODE_READBACK_ADDR: begin
                    q_next.rdata      = MODE_RB_FIXED | {5'h00, MODE_STRAP_PINS_IN};
                end
                SYS_CTRL_ADDR:   q_next.rdata = q_reg.sysctl | SYS_CTRL_ONES;
                AREA_WIDTH_ADDR: q_next.rdata = q_reg.area_w;
                AREA_WAIT_ADDR:  q_next.rdata = q_reg.area_t;
                default:         q_next.rdata = 8'h00;          // unmapped reads zero
            endcase
        end

        // register writes; readback ignores them
        if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                SYS_CTRL_ADDR: begin
                    q_next.sysctl = (REG_WDATA_IN & SYS_CTRL_WMASK) | SYS_CTRL_ONES;
                end
                AREA_WIDTH_ADDR: q_next.area_w = REG_WDATA_IN;
                AREA_WAIT_ADDR:  q_next.area_t = REG_WDATA_IN;
                default: begin
                end
            endcase
        end

        // user flag role, registered beside the control bits
        q_next.ufmask = !q_next.sysctl[SC_UFE_BIT];

        // data path width of the taken access
        if (acc_start) begin
            case (ACC_IN.space)
                SP_MEM:    q_next.acc_wide = 1'b1;
                SP_PERIPH: q_next.acc_wide = ACC_IN.reg16;
                default:   q_next.acc_wide = q_reg.ext16 && q_reg.area_w[ACC_IN.area];
            endcase
        end

        // power states
        case (q_reg.pwr)
            PWR_RUN: begin
                if (SLEEP_REQ_IN) begin
                    if (q_reg.sysctl[SC_STBY_BIT]) begin
                        q_next.pwr = PWR_STANDBY;
                    end else begin
                        q_next.pwr = PWR_SLEEP;
                    end
                end
            end
            PWR_SLEEP: begin
                if (WAKE_IRQ_IN) begin
                    q_next.pwr = PWR_RUN;
                end
            end
            PWR_STANDBY: begin
                // RAM enable is kept through standby
                if (EXT_IRQ_IN) begin
                    q_next.pwr        = PWR_SETTLE;
                    q_next.settle_cnt = wait_cycles - 18'h00001;
                end
            end
            PWR_SETTLE: begin
                // standby bit is left set on the way out
                if (q_reg.settle_cnt == 18'h00000) begin
                    q_next.pwr = PWR_RUN;
                end else begin
                    q_next.settle_cnt = q_reg.settle_cnt - 18'h00001;
                end
            end
            default: q_next.pwr = PWR_RUN;
        endcase
    end

    // state register
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            q_reg <= q_rst;
        end else begin
            q_reg <= q_next;
        end
    end

    // state timer for access cycles
    omsc_state_ctr u_ctr (
        .clk_in   (MCLK_IN),
        .srst_in  (SRST_IN),
        .start_in (acc_start),
        .len_in   (acc_len),
        .busy_out (ctr_busy),
        .last_out (ctr_last)
    );

    // outputs from flops
    assign REG_RDATA_OUT      = q_reg.rdata;
    assign PWR_STATE_OUT      = q_reg.pwr;
    assign WAIT_SHORT_OUT     = q_reg.wait_short;
    assign ACC_BUSY_OUT       = ctr_busy;
    assign ACC_DONE_OUT       = q_reg.acc_done;
    assign ACC_WIDE_OUT       = q_reg.acc_wide;
    assign MODE_CFG_OUT       = q_reg.cfg;
    assign EXT_BUS16_OUT      = q_reg.ext16;
    assign RAM_EN_OUT         = q_reg.sysctl[SC_RAM_BIT];
    assign RAM_TO_EXT_OUT     = q_reg.ram_ext;
    assign USER_FLAG_MASK_OUT = q_reg.ufmask;
    assign NMI_RISING_OUT     = q_reg.sysctl[SC_NMI_BIT];

    // checks
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);

    // readback shows fixed bits and straps of the read cycle
    mode_readback_a: assert property (
        (REG_RD_IN && REG_ADDR_IN == MODE_READBACK_ADDR)
        |=> (REG_RDATA_OUT == (8'hc0 | {5'h00, $past(MODE_STRAP_PINS_IN)})))
        else $error("mode readback wrong");

    // control reads show bit 1 set
    ctrl_reserved_a: assert property (
        (REG_RD_IN && REG_ADDR_IN == SYS_CTRL_ADDR) |=> REG_RDATA_OUT[1])
        else $error("reserved bit read as zero");

    // control reset value after release
    ctrl_reset_a: assert property (
        $fell(SRST_IN) |-> (q_reg.sysctl == 8'h0b && RAM_EN_OUT && !NMI_RISING_OUT))
        else $error("control reset value wrong");

    // sleep request lands in the selected state
    sleep_select_a: assert property (
        (q_reg.pwr == PWR_RUN && SLEEP_REQ_IN)
        |=> (PWR_STATE_OUT == ($past(q_reg.sysctl[7]) ? PWR_STANDBY : PWR_SLEEP)))
        else $error("wrong power state after sleep");

    // settle counter loaded with the coded length minus one
    settle_load_a: assert property (
        (q_reg.pwr == PWR_STANDBY && EXT_IRQ_IN)
        |=> (q_reg.settle_cnt == (18'(WAIT_BASE) << $past(wait_code)) - 18'h00001))
        else $error("settle length wrong");

    // standby bit still set on leaving settle
    standby_keep_a: assert property (
        (q_reg.pwr == PWR_SETTLE && q_reg.settle_cnt == 18'h00000 && !REG_WR_IN)
        |=> (PWR_STATE_OUT == PWR_RUN && q_reg.sysctl[7]))
        else $error("standby bit lost on wake");

    // on-chip memory access takes two states
    mem_access_a: assert property (
        (acc_start && ACC_IN.space == SP_MEM)
        |=> !ACC_DONE_OUT ##1 !ACC_DONE_OUT ##1 (ACC_DONE_OUT && ACC_WIDE_OUT))
        else $error("memory access length wrong");

    // peripheral access takes three states
    periph_access_a: assert property (
        (acc_start && ACC_IN.space == SP_PERIPH)
        |=> ACC_BUSY_OUT [*3] ##1 (ACC_DONE_OUT && !ACC_BUSY_OUT))
        else $error("peripheral access length wrong");

    // RAM routing follows the enable bit
    ram_route_a: assert property (
        ##1 (RAM_TO_EXT_OUT == ($past(q_reg.cfg.expanded) && !$past(RAM_EN_OUT))))
        else $error("RAM routing wrong");

    // bus width follows the area widths
    bus_width_a: assert property (
        (q_reg.cfg.expanded && q_reg.area_w != 8'h00) |=> EXT_BUS16_OUT)
        else $error("bus should be wide");

    // zero straps are no mode
    strap_zero_a: assert property (
        (MODE_STRAP_PINS_IN == 3'h0) |=> !MODE_CFG_OUT.valid)
        else $error("zero straps decoded as mode");

    // read data stands one cycle only
    rdata_idle_a: assert property (
        !REG_RD_IN |=> (REG_RDATA_OUT == 8'h00))
        else $error("read data not cleared");

    // control writes land, bit 1 kept high
    ctrl_write_a: assert property (
        (REG_WR_IN && REG_ADDR_IN == SYS_CTRL_ADDR)
        |=> (q_reg.sysctl[SC_STBY_BIT] == $past(REG_WDATA_IN[7]) && NMI_RISING_OUT == $past(REG_WDATA_IN[2])
             && q_reg.sysctl[1]))
        else $error("control write wrong");

    // user flag role follows bit 3
    user_flag_a: assert property (
        (REG_WR_IN && REG_ADDR_IN == SYS_CTRL_ADDR) |=> (USER_FLAG_MASK_OUT == !$past(REG_WDATA_IN[3])))
        else $error("user flag role wrong");

    // RAM enable follows bit 0
    ram_enable_a: assert property (
        (REG_WR_IN && REG_ADDR_IN == SYS_CTRL_ADDR) |=> (RAM_EN_OUT == $past(REG_WDATA_IN[0])))
        else $error("RAM enable wrong");

    // the wake interrupt ends sleep; EXT_IRQ_IN does not
    sleep_wake_a: assert property (
        (q_reg.pwr == PWR_SLEEP && WAKE_IRQ_IN) |=> (PWR_STATE_OUT == PWR_RUN))
        else $error("sleep not left on interrupt");

    // fast external area takes two states
    ext_fast_a: assert property (
        (acc_start && ACC_IN.space == SP_EXT && !q_reg.area_t[ACC_IN.area])
        |=> ACC_BUSY_OUT [*2] ##1 (ACC_DONE_OUT && !ACC_BUSY_OUT))
        else $error("external access length wrong");

endmodule

// ==== omsc_strap_model.sv ====
`timescale 1ns/1ns
module omsc_strap_model
    import omsc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    // board choice of mode
    input  wire logic [2:0] mode_sel_in,
    // strap levels to the block
    output logic      [2:0] strap_out
);
    // strap levels, a legal mode from time zero
    logic [2:0] strap_reg = 3'h1;

    // straps follow the board choice only while reset holds, then stay put
    always @(posedge clk_in) begin
        if (srst_in) begin
            strap_reg <= mode_sel_in;
        end
    end

    assign strap_out = strap_reg;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench
    import omsc_pkg::*;
;
    // clock, reset and register port
    logic        clk       = 1'b0;
    logic        srst      = 1'b1;
    logic [15:0] addr      = 16'h0000;
    logic [7:0]  wdata     = 8'h00;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [7:0]  rdata;
    // straps, power and access stimulus
    logic [2:0]  mode_sel  = 3'h1;
    logic [2:0]  strap;
    logic        sleep_req = 1'b0;
    logic        wake_irq  = 1'b0;
    logic        ext_irq   = 1'b0;
    omsc_acc_s   acc       = '0;
    // observed outputs
    omsc_pwr_e   pwr;
    omsc_mode_s  mode_cfg;
    logic        wait_short, busy, done, wide, bus16, ram_en, ram_ext, ufmask, nmi_rise;
    // bookkeeping
    omsc_mode_s  em;
    int          failures     = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    int          n;
    logic [7:0]  rv;

    // 20 MHz clock
    always #25 clk = ~clk;

    // hang guard, the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end

    omsc_strap_model straps (
        .clk_in      (clk),
        .srst_in     (srst),
        .mode_sel_in (mode_sel),
        .strap_out   (strap)
    );

    // short settle base keeps standby exits brief
    omsc_ctrl #(.WAIT_BASE(8)) dut (
        .MCLK_IN            (clk),
        .SRST_IN            (srst),
        .REG_ADDR_IN        (addr),
        .REG_WDATA_IN       (wdata),
        .REG_WR_IN          (wr),
        .REG_RD_IN          (rd),
        .REG_RDATA_OUT      (rdata),
        .MODE_STRAP_PINS_IN (strap),
        .SLEEP_REQ_IN       (sleep_req),
        .WAKE_IRQ_IN        (wake_irq),
        .EXT_IRQ_IN         (ext_irq),
        .PWR_STATE_OUT      (pwr),
        .WAIT_SHORT_OUT     (wait_short),
        .ACC_IN             (acc),
        .ACC_BUSY_OUT       (busy),
        .ACC_DONE_OUT       (done),
        .ACC_WIDE_OUT       (wide),
        .MODE_CFG_OUT       (mode_cfg),
        .EXT_BUS16_OUT      (bus16),
        .RAM_EN_OUT         (ram_en),
        .RAM_TO_EXT_OUT     (ram_ext),
        .USER_FLAG_MASK_OUT (ufmask),
        .NMI_RISING_OUT     (nmi_rise)
    );

    // counts and verdict, the single end of the run
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one compare, reported at once on mismatch
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic end_test(input string s);
        $display("test %s done, %0d checks so far", s, total_checks);
    endtask

    // let registered outputs catch up
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    // one-cycle write strobe
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the cycle after it
    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        rv = rdata;
        chk(name, {8'h00, exp}, {8'h00, rv});
    endtask

    // reset with a new strap choice
    task automatic do_reset(input logic [2:0] m);
        @(posedge clk);
        srst     <= 1'b1;
        mode_sel <= m;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        settle();
    endtask

    // one access; counts states from the take edge to the done pulse
    task automatic acc_run(input omsc_space_e sp, input logic [2:0] ar, input logic r16,
                           input int len, input logic exp_wide);
        @(posedge clk);
        acc <= '{req: 1'b1, space: sp, area: ar, reg16: r16};
        @(posedge clk);
        acc.req <= 1'b0;
        #1;
        chk("busy", 16'h0001, {15'h0, busy});
        chk("wide", {15'h0, exp_wide}, {15'h0, wide});
        n = 0;
        while (done !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("states", len[15:0], n[15:0]);
    endtask

    // sleep instruction, then the matching wake; counts settle cycles
    task automatic pwr_run(input omsc_pwr_e mid, input int wait_cyc);
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        #1;
        chk("power", {14'h0, mid}, {14'h0, pwr});
        @(posedge clk);
        wake_irq <= (mid == PWR_SLEEP);
        ext_irq  <= (mid == PWR_STANDBY);
        @(posedge clk);
        wake_irq <= 1'b0;
        ext_irq  <= 1'b0;
        #1;
        n = 0;
        while (pwr !== PWR_RUN && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("settle", wait_cyc[15:0], n[15:0]);
    endtask

    // expected decode of a strap pattern
    function automatic omsc_mode_s exp_mode(input int m);
        omsc_mode_s r;
        r.valid    = 1'b1;
        r.expanded = (m <= 5);
        r.rom_en   = (m >= 5);
        r.init16   = (m == 2 || m == 4);
        r.asz      = (m == 6) ? AS_64K : ((m == 3 || m == 4) ? AS_16M : AS_1M);
        if (m == 0) begin
            r = '0;
        end
        return r;
    endfunction

    // main sequence
    initial begin
        // every strap pattern from reset; pattern 0 only shows the unused decode
        for (int m = 0; m <= 7; m++) begin
            em = exp_mode(m);
            do_reset(m[2:0]);
            chk("mode", {10'h0, em}, {10'h0, mode_cfg});
            chk("bus16", {15'h0, em.init16}, {15'h0, bus16});
            rd_chk("readback", MODE_READBACK_ADDR, 8'hc0 | 8'(m));
            rd_chk("sysctrl", SYS_CTRL_ADDR, 8'h0b);
            rd_chk("width", AREA_WIDTH_ADDR, em.init16 ? 8'hff : 8'h00);
        end
        end_test("modes");
        // control register fields and read-only places
        do_reset(3'h1);
        chk("ram_en", 16'h0001, {15'h0, ram_en});
        reg_wr(SYS_CTRL_ADDR, 8'h00);
        settle();
        rd_chk("sysctrl", SYS_CTRL_ADDR, 8'h02);
        chk("ram_en", 16'h0000, {15'h0, ram_en});
        chk("ram_ext", 16'h0001, {15'h0, ram_ext});
        chk("ufmask", 16'h0001, {15'h0, ufmask});
        reg_wr(SYS_CTRL_ADDR, 8'h0d);
        settle();
        rd_chk("sysctrl", SYS_CTRL_ADDR, 8'h0f);
        chk("nmi", 16'h0001, {15'h0, nmi_rise});
        chk("ufmask", 16'h0000, {15'h0, ufmask});
        chk("ram_ext", 16'h0000, {15'h0, ram_ext});
        reg_wr(MODE_READBACK_ADDR, 8'h00);
        rd_chk("readback", MODE_READBACK_ADDR, 8'hc1);
        rd_chk("unmapped", 16'h1234, 8'h00);
        end_test("control");
        // area widths and access lengths
        chk("bus16", 16'h0000, {15'h0, bus16});
        reg_wr(AREA_WIDTH_ADDR, 8'h01);
        reg_wr(AREA_WAIT_ADDR, 8'hfe);
        settle();
        chk("bus16", 16'h0001, {15'h0, bus16});
        acc_run(SP_MEM, 3'h0, 1'b0, 2, 1'b1);
        acc_run(SP_PERIPH, 3'h0, 1'b0, 3, 1'b0);
        acc_run(SP_PERIPH, 3'h5, 1'b1, 3, 1'b1);
        acc_run(SP_EXT, 3'h0, 1'b0, 2, 1'b1);
        acc_run(SP_EXT, 3'h7, 1'b0, 3, 1'b0);
        reg_wr(AREA_WIDTH_ADDR, 8'h00);
        settle();
        chk("bus16", 16'h0000, {15'h0, bus16});
        end_test("access");
        // sleep, then standby with several wait codes, the last one illegal
        reg_wr(SYS_CTRL_ADDR, 8'h0b);
        pwr_run(PWR_SLEEP, 0);
        for (int c = 0; c <= 6; c += 2) begin
            reg_wr(SYS_CTRL_ADDR, 8'h8b | 8'(c << 4));
            settle();
            chk("short", 16'h0001, {15'h0, wait_short});
            pwr_run(PWR_STANDBY, 8 << ((c > 4) ? 4 : c));
            rd_chk("sysctrl", SYS_CTRL_ADDR, 8'h8b | 8'(c << 4));
        end
        reg_wr(SYS_CTRL_ADDR, 8'h0b);
        rd_chk("sysctrl", SYS_CTRL_ADDR, 8'h0b);
        end_test("power");
        finish_test();
    end
endmodule
